/* File: core/blc_backlight_regs.sv */
// Backlight configuration, sink enable and off/dim timeout register bank.
// How it works
// - Level field reports operating level; automatic comparator updates overwrite software writes.
// - Level code 00 selects level 1, 01 level 2, 10 level 3.
// - Level code 11 drives backlight current to zero.
// - Law code 00 selects linear DAC with linear time steps.
// - Law code 01 selects square-law DAC with linear time steps.
// - Law codes 10 and 11 select square-law DAC, two nonlinear fade profiles.
// - Configuration bit 0 enables the fade override when set.
// - A set sink enable bit makes that sink independently controlled.
// - A cleared sink enable bit makes that sink follow the backlight group.
// - Expiry of the programmed off timeout switches the backlight off.
// - With dim timeout enabled, off timeout counts only after dim expiry.
// - Off timeout is value seconds, 1 to 127; zero disables it.
// - Dim timeout starts at maximum current and then selects dim current.
`timescale 1ns/10ps

module blc_backlight_regs #(
    parameter int unsigned TICK_CYCLES = blc_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic reg_write,
    input wire logic [7:0] reg_address,
    input wire logic [7:0] reg_write_data,
    output logic [7:0] reg_read_data,
    input wire logic backlight_group_enable,
    input wire logic at_max_current,
    input wire logic auto_light_control_enable,
    input wire logic auto_level_update,
    input wire logic [1:0] auto_level,
    output logic [1:0] brightness_level,
    output logic [1:0] transfer_law,
    output logic fade_override,
    output logic [6:0] sink_independent,
    output logic [6:0] sink_group_on,
    output logic backlight_lit,
    output logic backlight_current_zero,
    output logic backlight_dimmed,
    output logic [1:0] level_number,
    output logic dac_square_law,
    output logic nonlinear_steps,
    output logic cubic_profile
);

    if (TICK_CYCLES < 2 || TICK_CYCLES > (1 << blc_pkg::TICK_WIDTH)) begin : g_tick_check
        $error("blc_backlight_regs: TICK_CYCLES does not fit the prescaler");
    end

    localparam logic [24:0] TICK_LAST = 25'(TICK_CYCLES - 1);

    blc_pkg::blc_core_s r;
    blc_pkg::blc_core_s next_r;
    logic dim_run;
    logic off_run;
    logic dim_expired;
    logic off_expired;
    logic group_rise;
    logic wr_cfg;
    logic wr_sink;
    logic wr_off;
    logic wr_dim;
    logic restart;

    // Write decode is used four times, so it is one function.
    function automatic logic hits(input logic wr, input logic [7:0] a, input logic [7:0] off);
        hits = wr && (a == off);
    endfunction

    assign wr_cfg = hits(reg_write, reg_address, blc_pkg::CFG_OFFSET);
    assign wr_sink = hits(reg_write, reg_address, blc_pkg::SINK_OFFSET);
    assign wr_off = hits(reg_write, reg_address, blc_pkg::OFF_OFFSET);
    assign wr_dim = hits(reg_write, reg_address, blc_pkg::DIM_OFFSET);
    assign group_rise = backlight_group_enable && !r.group_q;
    assign restart = group_rise || wr_off || wr_dim;

    // Dim runs first at full current; off runs after dim, or at full when dim is off.
    assign dim_run = (r.state == blc_pkg::BL_FULL) && (r.dim_delay != '0);
    assign off_run = ((r.state == blc_pkg::BL_FULL) && (r.dim_delay == '0))
                     || (r.state == blc_pkg::BL_DIM);

    blc_second_timer #(
        .DELAY_WIDTH(blc_pkg::DELAY_WIDTH)
    ) u_dim_timer (
        .clock(clock),
        .reset_n(reset_n),
        .tick(r.tick),
        .run(dim_run),
        .restart(restart),
        .delay(r.dim_delay),
        .expired(dim_expired)
    );

    blc_second_timer #(
        .DELAY_WIDTH(blc_pkg::DELAY_WIDTH)
    ) u_off_timer (
        .clock(clock),
        .reset_n(reset_n),
        .tick(r.tick),
        .run(off_run),
        .restart(restart),
        .delay(r.off_delay),
        .expired(off_expired)
    );

    // Next state: register writes, level updates, second tick, sequence and outputs.
    always_comb begin
        next_r = r;
        next_r.group_q = backlight_group_enable;

        // Software writes; reserved bit 7 is never stored.
        if (wr_cfg) begin
            next_r.fade = reg_write_data[blc_pkg::FADE_BIT];
            next_r.law = reg_write_data[blc_pkg::LAW_LSB +: 2];
            next_r.level = reg_write_data[blc_pkg::LEVEL_LSB +: 2];
            next_r.cmp2_sel = reg_write_data[blc_pkg::CMP2_SEL_BIT];
            next_r.sel_ab = reg_write_data[blc_pkg::SEL_AB_BIT];
        end
        if (wr_sink) begin
            next_r.sink_en = reg_write_data[6:0];
        end
        if (wr_off) begin
            next_r.off_delay = reg_write_data[6:0];
        end
        if (wr_dim) begin
            next_r.dim_delay = reg_write_data[6:0];
        end
        // The comparator update comes after the write so it wins a same-cycle clash.
        if (auto_light_control_enable && auto_level_update) begin
            next_r.level = auto_level;
        end

        // Prescaler restarts, dim expiry included, so each phase counts a full first second.
        next_r.tick = 1'b0;
        if (restart || dim_expired || !(dim_run || off_run)) begin
            next_r.prescale = '0;
        end else if (r.prescale == TICK_LAST) begin
            next_r.prescale = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.prescale = 25'(r.prescale + 1'b1);
        end

        // Backlight sequence.
        unique case (r.state)
            blc_pkg::BL_IDLE: begin
                if (backlight_group_enable) begin
                    next_r.state = blc_pkg::BL_RAMP;
                end
            end
            blc_pkg::BL_RAMP: begin
                if (at_max_current) begin
                    next_r.state = blc_pkg::BL_FULL;
                end
            end
            blc_pkg::BL_FULL: begin
                if (dim_expired) begin
                    next_r.state = blc_pkg::BL_DIM;
                end else if (off_expired) begin
                    next_r.state = blc_pkg::BL_TIMED_OFF;
                end
            end
            blc_pkg::BL_DIM: begin
                if (off_expired) begin
                    next_r.state = blc_pkg::BL_TIMED_OFF;
                end
            end
            blc_pkg::BL_TIMED_OFF: begin
                next_r.state = blc_pkg::BL_TIMED_OFF;
            end
            default: begin
                next_r.state = blc_pkg::BL_IDLE;
            end
        endcase
        if (!backlight_group_enable) begin
            next_r.state = blc_pkg::BL_IDLE;
        end

        // Registered outputs follow the current stored state by one cycle.
        next_r.lit = (r.state == blc_pkg::BL_RAMP || r.state == blc_pkg::BL_FULL
                      || r.state == blc_pkg::BL_DIM) && (r.level != blc_pkg::LEVEL_OFF);
        next_r.current_zero = !next_r.lit;
        next_r.dimmed = (r.state == blc_pkg::BL_DIM);
        next_r.sink_group_on = ~r.sink_en & {blc_pkg::SINK_COUNT{next_r.lit}};
        unique case (r.level)
            blc_pkg::LEVEL_DAYLIGHT: next_r.level_number = 2'h1;
            blc_pkg::LEVEL_OFFICE: next_r.level_number = 2'h2;
            blc_pkg::LEVEL_DARK: next_r.level_number = 2'h3;
            blc_pkg::LEVEL_OFF: next_r.level_number = 2'h0;
        endcase
        next_r.square_law = (r.law != blc_pkg::LAW_LINEAR);
        next_r.nonlinear_steps = r.law[1];
        next_r.cubic_profile = r.law[1] && r.law[0];

        // Read data is registered: one cycle after the address is presented.
        unique case (reg_address)
            blc_pkg::CFG_OFFSET: next_r.read_data = {1'b0, r.sel_ab, r.cmp2_sel, r.level,
                                                     r.law, r.fade};
            blc_pkg::SINK_OFFSET: next_r.read_data = {1'b0, r.sink_en};
            blc_pkg::OFF_OFFSET: next_r.read_data = {1'b0, r.off_delay};
            blc_pkg::DIM_OFFSET: next_r.read_data = {1'b0, r.dim_delay};
            default: next_r.read_data = 8'h00;
        endcase
    end

    // State register; all control state starts at its documented or zero value.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            r <= '0;
            r.current_zero <= 1'b1;
            r.level_number <= 2'h1;
        end else begin
            r <= next_r;
        end
    end

    // Outputs come straight from the state register.
    assign reg_read_data = r.read_data;
    assign brightness_level = r.level;
    assign transfer_law = r.law;
    assign fade_override = r.fade;
    assign sink_independent = r.sink_en;
    assign sink_group_on = r.sink_group_on;
    assign backlight_lit = r.lit;
    assign backlight_current_zero = r.current_zero;
    assign backlight_dimmed = r.dimmed;
    assign level_number = r.level_number;
    assign dac_square_law = r.square_law;
    assign nonlinear_steps = r.nonlinear_steps;
    assign cubic_profile = r.cubic_profile;

    // Checks tie each output but transfer_law and sink_independent to its cause.
    property p_auto_level;
        @(posedge clock) disable iff (!reset_n)
        auto_light_control_enable && auto_level_update |=> brightness_level == $past(auto_level);
    endproperty
    a_auto_level: assert property (p_auto_level) else $error("auto level lost");

    property p_level_map;
        @(posedge clock) disable iff (!reset_n)
        brightness_level != blc_pkg::LEVEL_OFF
        |=> level_number == 2'($past(brightness_level) + 1'b1);
    endproperty
    a_level_map: assert property (p_level_map) else $error("level number wrong");

    property p_level_off;
        @(posedge clock) disable iff (!reset_n)
        brightness_level == blc_pkg::LEVEL_OFF |=> backlight_current_zero && sink_group_on == '0;
    endproperty
    a_level_off: assert property (p_level_off) else $error("off level lit");

    property p_law_linear;
        @(posedge clock) disable iff (!reset_n)
        transfer_law == blc_pkg::LAW_LINEAR |=> !dac_square_law && !nonlinear_steps;
    endproperty
    a_law_linear: assert property (p_law_linear) else $error("linear law wrong");

    property p_law_square;
        @(posedge clock) disable iff (!reset_n)
        transfer_law == blc_pkg::LAW_SQUARE |=> dac_square_law && !nonlinear_steps;
    endproperty
    a_law_square: assert property (p_law_square) else $error("square law wrong");

    property p_law_cubic;
        @(posedge clock) disable iff (!reset_n)
        transfer_law[1] |=> dac_square_law && nonlinear_steps
                            && cubic_profile == $past(transfer_law[0]);
    endproperty
    a_law_cubic: assert property (p_law_cubic) else $error("cubic law wrong");

    property p_fade;
        @(posedge clock) disable iff (!reset_n)
        wr_cfg |=> fade_override == $past(reg_write_data[0]);
    endproperty
    a_fade: assert property (p_fade) else $error("fade override not stored");

    property p_sink_group;
        @(posedge clock) disable iff (!reset_n)
        ##1 (sink_group_on & $past(sink_independent)) == '0;
    endproperty
    a_sink_group: assert property (p_sink_group) else $error("independent sink grouped");

    property p_sink_follow;
        @(posedge clock) disable iff (!reset_n)
        backlight_lit ##1 backlight_lit |-> sink_group_on == ~$past(sink_independent);
    endproperty
    a_sink_follow: assert property (p_sink_follow) else $error("grouped sink dark");

    property p_off_expiry;
        @(posedge clock) disable iff (!reset_n)
        off_expired && backlight_group_enable
        |=> r.state == blc_pkg::BL_TIMED_OFF ##2 !backlight_lit;
    endproperty
    a_off_expiry: assert property (p_off_expiry) else $error("off timeout ignored");

    property p_off_after_dim;
        @(posedge clock) disable iff (!reset_n)
        r.dim_delay != '0 && r.state == blc_pkg::BL_FULL |-> !off_run;
    endproperty
    a_off_after_dim: assert property (p_off_after_dim) else $error("off ran with dim");

    property p_dim_expiry;
        @(posedge clock) disable iff (!reset_n)
        dim_expired && backlight_group_enable |=> r.state == blc_pkg::BL_DIM ##1 backlight_dimmed;
    endproperty
    a_dim_expiry: assert property (p_dim_expiry) else $error("dim timeout ignored");

    property p_reserved;
        @(posedge clock) disable iff (!reset_n)
        reg_address == blc_pkg::SINK_OFFSET || reg_address == blc_pkg::OFF_OFFSET
        |=> !reg_read_data[7];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    c_dim_then_off: cover property (@(posedge clock) disable iff (!reset_n)
        r.state == blc_pkg::BL_DIM ##1 r.state == blc_pkg::BL_TIMED_OFF);
    c_full_off: cover property (@(posedge clock) disable iff (!reset_n)
        r.state == blc_pkg::BL_FULL ##1 r.state == blc_pkg::BL_TIMED_OFF);
    c_auto_clash: cover property (@(posedge clock) disable iff (!reset_n)
        wr_cfg && auto_light_control_enable && auto_level_update);

endmodule

/* File: include/blc_pkg.sv */
// Shared constants, state codes and the core state record of the backlight register bank.
package blc_pkg;

    // Register offsets on the serial register port.
    localparam logic [7:0] CFG_OFFSET = 8'h04;
    localparam logic [7:0] SINK_OFFSET = 8'h05;
    localparam logic [7:0] OFF_OFFSET = 8'h06;
    localparam logic [7:0] DIM_OFFSET = 8'h07;

    // Field positions inside the configuration register.
    localparam int unsigned FADE_BIT = 0;
    localparam int unsigned LAW_LSB = 1;
    localparam int unsigned LEVEL_LSB = 3;
    localparam int unsigned CMP2_SEL_BIT = 5;
    localparam int unsigned SEL_AB_BIT = 6;

    // Field widths.
    localparam int unsigned SINK_COUNT = 7;
    localparam int unsigned DELAY_WIDTH = 7;
    localparam int unsigned TICK_WIDTH = 25;

    // Reset values of the stored fields.
    localparam logic [1:0] LEVEL_RESET = 2'h0;
    localparam logic [1:0] LAW_RESET = 2'h0;
    localparam logic [6:0] SINK_RESET = 7'h00;
    localparam logic [6:0] DELAY_RESET = 7'h00;

    // Level and law codes.
    localparam logic [1:0] LEVEL_DAYLIGHT = 2'h0;
    localparam logic [1:0] LEVEL_OFFICE = 2'h1;
    localparam logic [1:0] LEVEL_DARK = 2'h2;
    localparam logic [1:0] LEVEL_OFF = 2'h3;
    localparam logic [1:0] LAW_LINEAR = 2'h0;
    localparam logic [1:0] LAW_SQUARE = 2'h1;

    // Timeout unit: one second, counted in clock cycles at 20 MHz.
    localparam int unsigned SECOND_S = 1;
    localparam int unsigned CLOCK_HZ = 20000000;
    localparam int unsigned TICK_CYCLES = SECOND_S * CLOCK_HZ;

    // Backlight sequence states.
    typedef enum logic [2:0] {
        BL_IDLE = 3'b000,
        BL_RAMP = 3'b001,
        BL_FULL = 3'b010,
        BL_DIM = 3'b011,
        BL_TIMED_OFF = 3'b100
    } blc_state_e;

    // Whole state of the register bank core.
    typedef struct packed {
        blc_state_e state;
        logic [1:0] level;
        logic [1:0] law;
        logic fade;
        logic cmp2_sel;
        logic sel_ab;
        logic [6:0] sink_en;
        logic [6:0] off_delay;
        logic [6:0] dim_delay;
        logic [24:0] prescale;
        logic tick;
        logic group_q;
        logic [7:0] read_data;
        logic lit;
        logic current_zero;
        logic dimmed;
        logic [1:0] level_number;
        logic square_law;
        logic nonlinear_steps;
        logic cubic_profile;
        logic [6:0] sink_group_on;
    } blc_core_s;

endpackage

/* File: core/blc_second_timer.sv */
// Whole-second countdown used for the dim and off timeouts.
`timescale 1ns/10ps

module blc_second_timer #(
    parameter int unsigned DELAY_WIDTH = 7
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic tick,
    input wire logic run,
    input wire logic restart,
    input wire logic [DELAY_WIDTH-1:0] delay,
    output logic expired
);

    if (DELAY_WIDTH < 1 || DELAY_WIDTH > 16) begin : g_width_check
        $error("blc_second_timer: DELAY_WIDTH out of range");
    end

    typedef struct packed {
        logic [DELAY_WIDTH-1:0] secs;
        logic expired;
    } blc_timer_s;

    blc_timer_s r;
    blc_timer_s next_r;

    // Count whole seconds while running; a zero delay never expires.
    always_comb begin
        next_r = r;
        next_r.expired = 1'b0;
        if (!run || restart) begin
            next_r.secs = '0;
        end else if (tick && delay != '0) begin
            if (DELAY_WIDTH'(r.secs + 1'b1) == delay) begin
                next_r.expired = 1'b1;
                next_r.secs = '0;
            end else begin
                next_r.secs = DELAY_WIDTH'(r.secs + 1'b1);
            end
        end
    end

    // State register.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign expired = r.expired;

    property p_restart_clears;
        @(posedge clock) disable iff (!reset_n)
        restart |=> (r.secs == '0) && !expired;
    endproperty
    a_restart_clears: assert property (p_restart_clears) else $error("timer not cleared");

    property p_expiry_count;
        @(posedge clock) disable iff (!reset_n)
        expired |-> $past(delay) != '0 && $past(r.secs) == DELAY_WIDTH'($past(delay) - 1'b1);
    endproperty
    a_expiry_count: assert property (p_expiry_count) else $error("early expiry");

endmodule

/* File: bench/blc_host_model.sv */
// Host model that writes and reads the backlight register bank.
`timescale 1ns/10ps

module blc_host_model (
    input wire logic clock,
    output logic reg_write,
    output logic [7:0] reg_address,
    output logic [7:0] reg_write_data,
    input wire logic [7:0] reg_read_data
);
    // The bus starts idle.
    initial begin
        reg_write = 1'b0;
        reg_address = 8'h00;
        reg_write_data = 8'h00;
    end

    // One single-cycle strobe, taken at the following rising edge.
    // Idle data shows the inverse so a stale value is never taken for fresh.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock);
        reg_write = 1'b1;
        reg_address = addr;
        reg_write_data = data;
        @(negedge clock);
        reg_write = 1'b0;
        reg_write_data = ~data;
    endtask

    // Read data is registered, so it stands one cycle after the address.
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clock);
        reg_address = addr;
        @(negedge clock);
        data = reg_read_data;
    endtask
endmodule

/* File: bench/blc_backlight_regs_tb_top.sv */
// Self-checking bench for the backlight register bank.
`timescale 1ns/10ps

module blc_backlight_regs_tb_top;
    localparam int unsigned TICKS = 16;
    localparam int LIMIT = 12000;
    logic clock;
    logic reset_n;
    logic reg_write;
    logic [7:0] reg_address;
    logic [7:0] reg_write_data;
    logic [7:0] reg_read_data;
    logic backlight_group_enable;
    logic at_max_current;
    logic auto_light_control_enable;
    logic auto_level_update;
    logic [1:0] auto_level;
    logic [1:0] brightness_level;
    logic [1:0] transfer_law;
    logic fade_override;
    logic [6:0] sink_independent;
    logic [6:0] sink_group_on;
    logic backlight_lit;
    logic backlight_current_zero;
    logic backlight_dimmed;
    logic [1:0] level_number;
    logic dac_square_law;
    logic nonlinear_steps;
    logic cubic_profile;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;

    // A short tick keeps whole-second timeouts within a brief run.
    blc_backlight_regs #(.TICK_CYCLES(TICKS)) dut (
        .clock(clock), .reset_n(reset_n), .reg_write(reg_write),
        .reg_address(reg_address), .reg_write_data(reg_write_data),
        .reg_read_data(reg_read_data), .backlight_group_enable(backlight_group_enable),
        .at_max_current(at_max_current),
        .auto_light_control_enable(auto_light_control_enable),
        .auto_level_update(auto_level_update), .auto_level(auto_level),
        .brightness_level(brightness_level), .transfer_law(transfer_law),
        .fade_override(fade_override), .sink_independent(sink_independent),
        .sink_group_on(sink_group_on), .backlight_lit(backlight_lit),
        .backlight_current_zero(backlight_current_zero),
        .backlight_dimmed(backlight_dimmed), .level_number(level_number),
        .dac_square_law(dac_square_law), .nonlinear_steps(nonlinear_steps),
        .cubic_profile(cubic_profile)
    );

    blc_host_model host (
        .clock(clock), .reg_write(reg_write), .reg_address(reg_address),
        .reg_write_data(reg_write_data), .reg_read_data(reg_read_data)
    );

    // Free-running 20 MHz clock.
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // A hung wait is cut short here and counted as a mismatch.
    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic test_reset;
        logic [7:0] d;
        for (int a = 4; a < 8; a++) begin
            host.read_reg(8'(a), d);
            check("reset readback", 8'h00, d);
        end
        check("reset level number", 8'h01, {6'h00, level_number});
        check("reset current zero", 8'h01, {7'h00, backlight_current_zero});
        $display("test_reset done");
    endtask

    // Every level and law code, with bit 7 set to prove it is dropped.
    task automatic test_config;
        logic [7:0] d;
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            host.write_reg(blc_pkg::CFG_OFFSET, {3'h4, c, c, c[0]});
            repeat (2) @(negedge clock);
            check("level", {6'h00, c}, {6'h00, brightness_level});
            check("level number", (i == 3) ? 8'h00 : 8'(i + 1), {6'h00, level_number});
            check("law", {6'h00, c}, {6'h00, transfer_law});
            check("square", {7'h00, c != 2'h0}, {7'h00, dac_square_law});
            check("nonlinear", {7'h00, c[1]}, {7'h00, nonlinear_steps});
            check("cubic", {7'h00, c == 2'h3}, {7'h00, cubic_profile});
            check("fade", {7'h00, c[0]}, {7'h00, fade_override});
            host.read_reg(blc_pkg::CFG_OFFSET, d);
            check("cfg readback", {3'h0, c, c, c[0]}, d);
        end
        $display("test_config done");
    endtask

    task automatic test_sink;
        logic [7:0] d;
        host.write_reg(blc_pkg::SINK_OFFSET, 8'hff);
        host.read_reg(blc_pkg::SINK_OFFSET, d);
        check("sink readback", 8'h7f, d);
        host.write_reg(blc_pkg::SINK_OFFSET, 8'h2a);
        host.write_reg(8'h09, 8'hff);
        host.read_reg(8'h09, d);
        check("unmapped readback", 8'h00, d);
        check("sink independent", 8'h2a, {1'b0, sink_independent});
        $display("test_sink done");
    endtask

    // Lights the backlight and times the dim phase and the switch-off.
    task automatic run_light(input logic [6:0] dim, input logic [6:0] off,
                             output int t_dim, output int t_off);
        host.write_reg(blc_pkg::CFG_OFFSET, 8'h00);
        host.write_reg(blc_pkg::DIM_OFFSET, {1'b0, dim});
        host.write_reg(blc_pkg::OFF_OFFSET, {1'b0, off});
        @(negedge clock);
        backlight_group_enable = 1'b1;
        at_max_current = 1'b1;
        t_dim = 0;
        t_off = 0;
        for (int n = 1; n < 3000 && t_off == 0; n++) begin
            @(negedge clock);
            if (backlight_dimmed === 1'b1 && t_dim == 0) t_dim = n;
            if (n > 4 && backlight_lit !== 1'b1) t_off = n;
        end
    endtask

    task automatic drop_enable;
        @(negedge clock);
        backlight_group_enable = 1'b0;
        at_max_current = 1'b0;
        repeat (4) @(negedge clock);
    endtask

    // Parallel counting would switch off near one second, not three.
    task automatic test_timers;
        int td;
        int tf;
        run_light(7'h02, 7'h01, td, tf);
        check("dim time", 8'h01, {7'h00, td >= 2 * TICKS && td <= 2 * TICKS + 12});
        check("dim then off", 8'h01, {7'h00, tf >= 3 * TICKS && tf <= 3 * TICKS + 16});
        drop_enable();
        run_light(7'h00, 7'h02, td, tf);
        check("no dim phase", 8'h00, 8'(td));
        check("off only", 8'h01, {7'h00, tf >= 2 * TICKS && tf <= 2 * TICKS + 16});
        drop_enable();
        run_light(7'h00, 7'h00, td, tf);
        check("zero never offs", 8'h00, 8'(tf));
        check("grouped sinks", 8'h55, {1'b0, sink_group_on});
        host.write_reg(blc_pkg::CFG_OFFSET, 8'h18);
        repeat (3) @(negedge clock);
        check("level off zero", 8'h01, {7'h00, backlight_current_zero});
        drop_enable();
        $display("test_timers done");
    endtask

    // A comparator update wins over a software level write in the same cycle.
    task automatic test_auto;
        logic [7:0] d;
        auto_light_control_enable = 1'b1;
        auto_level = 2'h2;
        fork
            host.write_reg(blc_pkg::CFG_OFFSET, 8'h08);
            begin
                @(negedge clock);
                auto_level_update = 1'b1;
                @(negedge clock);
                auto_level_update = 1'b0;
            end
        join
        host.read_reg(blc_pkg::CFG_OFFSET, d);
        check("auto level readback", 8'h10, d);
        check("auto level", 8'h02, {6'h00, brightness_level});
        $display("test_auto done");
    endtask

    // Inputs start defined and change only at falling edges.
    initial begin
        reset_n = 1'b0;
        backlight_group_enable = 1'b0;
        at_max_current = 1'b0;
        auto_light_control_enable = 1'b0;
        auto_level_update = 1'b0;
        auto_level = 2'h0;
        repeat (20) @(negedge clock);
        reset_n = 1'b1;
        test_reset();
        test_config();
        test_sink();
        test_timers();
        test_auto();
        give_verdict();
    end
endmodule
